//--- verilog/wdg_pkg.sv
// constants and carrier types shared by the watchdog down counter files
package wdg_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CTRL_ADDR = 12'h0D8;
    localparam logic [7:0] CTRL_RESET = 8'hFE;
    localparam int unsigned BIT_ACT = 0;
    localparam int unsigned BIT_SRST = 1;
    localparam int unsigned CNT_W = 7;
    localparam int unsigned CNT_MSB = 6;
    localparam int unsigned PERIOD_BITS = 6;
    localparam logic [6:0] CNT_RESET = 7'h7F;
    localparam logic [6:0] CNT_LAST_SAFE = 7'h40;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned PRE_DIV = 12;
    localparam int unsigned POST_DIV = 256;
    localparam int unsigned TICK_CYCLES = PRE_DIV * POST_DIV;
    localparam logic [3:0] PRE_LAST = 4'(PRE_DIV - 1);
    localparam logic [7:0] POST_LAST = 8'(POST_DIV - 1);
    localparam logic [11:0] GAP_LAST = 12'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } wdg_apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } wdg_apb_rsp_t;

    typedef struct packed {
        logic [3:0] pre;
        logic [7:0] post;
        logic tick;
        logic [11:0] gap;
    } wdg_pre_state_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic act;
        logic stop;
        logic rst_req;
        logic pready;
        logic [7:0] rdata;
        logic pslverr;
        logic first;
        logic hw_s1;
        logic hw_s2;
        logic es_s1;
        logic es_s2;
        logic nmi_s1;
        logic nmi_s2;
    } wdg_state_t;
endpackage

//--- verilog/wdg_prescaler.sv
// divide-by-12 then divide-by-256 prescaler giving one tick per 3072 clocks
module wdg_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic run,
    output logic tick
);
    wdg_pkg::wdg_pre_state_t s_reg;
    wdg_pkg::wdg_pre_state_t s_next;

    // ------------------------------------------------------------------
    // divider chain
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (clear) begin
            s_next.pre = '0;
            s_next.post = '0;
            s_next.gap = '0;
        end else if (run) begin
            s_next.gap = s_reg.gap + 12'h001;
            if (s_reg.pre == wdg_pkg::PRE_LAST) begin
                s_next.pre = '0;
                if (s_reg.post == wdg_pkg::POST_LAST) begin
                    s_next.post = '0;
                    s_next.tick = 1'b1;
                    s_next.gap = '0;
                end else begin
                    s_next.post = s_reg.post + 8'h01;
                end
            end else begin
                s_next.pre = s_reg.pre + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        (run && !clear && s_reg.pre == wdg_pkg::PRE_LAST && s_reg.post == wdg_pkg::POST_LAST)
        |-> (s_reg.gap == wdg_pkg::GAP_LAST) ##1 tick)
        else $error("prescaler tick not 3072 clocks apart");
endmodule

//--- verilog/wdg_top.sv
// watchdog down counter with its control register on an APB slave
//
// The APB slave port was chosen for this implementation.
module wdg_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire wdg_pkg::wdg_apb_req_t apb_req,
    output wdg_pkg::wdg_apb_rsp_t apb_rsp,
    input wire logic hw_activation,
    input wire logic ext_stop_ctrl,
    input wire logic nmi_pin,
    input wire logic stop_req,
    input wire logic wake_irq,
    output logic mcu_reset_req,
    output logic stop_mode
);
    wdg_pkg::wdg_state_t s_reg;
    wdg_pkg::wdg_state_t s_next;
    logic tick;
    logic active;
    logic hit;
    logic wr;

    // ------------------------------------------------------------------
    // register image mapping
    // ------------------------------------------------------------------
    // the period bits sit reversed in the register, so both directions
    // go through these two functions
    function automatic logic [7:0] to_image(input logic [6:0] cnt, input logic act);
        logic [7:0] r;
        r = '0;
        r[wdg_pkg::BIT_ACT] = act;
        r[wdg_pkg::BIT_SRST] = cnt[wdg_pkg::CNT_MSB];
        for (int i = 0; i < wdg_pkg::PERIOD_BITS; i++) begin
            r[7 - i] = cnt[i];
        end
        return r;
    endfunction

    function automatic logic [6:0] from_image(input logic [7:0] r);
        logic [6:0] c;
        c = '0;
        c[wdg_pkg::CNT_MSB] = r[wdg_pkg::BIT_SRST];
        // six period bits set the low counter bits
        for (int i = 0; i < wdg_pkg::PERIOD_BITS; i++) begin
            c[i] = r[7 - i];
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // hardware option forces activation
    assign active = s_reg.act | s_reg.hw_s2;
    assign hit = (apb_req.paddr == wdg_pkg::CTRL_ADDR);
    assign wr = apb_req.psel & apb_req.penable & s_reg.pready & apb_req.pwrite & hit
        & apb_req.pstrb[0];

    // every control register write with pstrb[0] set restarts the tick, so a first timeout is a full tick
    wdg_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .clear(wr),
        .run(~s_reg.stop),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.first = 1'b0;
        s_next.hw_s1 = hw_activation;
        s_next.hw_s2 = s_reg.hw_s1;
        s_next.es_s1 = ext_stop_ctrl;
        s_next.es_s2 = s_reg.es_s1;
        s_next.nmi_s1 = nmi_pin;
        s_next.nmi_s2 = s_reg.nmi_s1;

        // zero wait state: answer in the cycle after setup
        s_next.pready = apb_req.psel & ~apb_req.penable;
        if (apb_req.psel && !apb_req.penable) begin
            if (hit) begin
                s_next.rdata = to_image(s_reg.cnt, active);
                s_next.pslverr = 1'b0;
            end else begin
                s_next.rdata = '0;
                s_next.pslverr = 1'b1;
            end
        end

        // stop is only real when the oscillator may halt
        if (s_reg.stop) begin
            if (wake_irq) begin
                s_next.stop = 1'b0;
            end
        end else if (stop_req) begin
            if (!active) begin
                s_next.stop = 1'b1;
            end else if (s_reg.es_s2 && s_reg.nmi_s2) begin
                s_next.stop = 1'b1;
            end
        end

        if (wr) begin
            s_next.cnt = from_image(apb_req.pwdata[7:0]);
            s_next.act = s_reg.act | apb_req.pwdata[wdg_pkg::BIT_ACT];
            if (!apb_req.pwdata[wdg_pkg::BIT_SRST]) begin
                s_next.rst_req = 1'b1;
            end
        end else if (tick && !s_reg.stop) begin
            // plain wrapping timer when not active
            s_next.cnt = s_reg.cnt - 7'h01;
            if (active && s_reg.cnt[wdg_pkg::CNT_MSB] && !s_next.cnt[wdg_pkg::CNT_MSB]) begin
                s_next.rst_req = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.cnt <= wdg_pkg::CNT_RESET;
            s_reg.act <= wdg_pkg::CTRL_RESET[wdg_pkg::BIT_ACT];
            s_reg.first <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign apb_rsp.pready = s_reg.pready;
    assign apb_rsp.prdata = {24'h000000, s_reg.rdata};
    assign apb_rsp.pslverr = s_reg.pslverr;
    assign mcu_reset_req = s_reg.rst_req;
    assign stop_mode = s_reg.stop;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_reset_image: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.first |-> (to_image(s_reg.cnt, s_reg.act) == wdg_pkg::CTRL_RESET))
        else $error("register image after reset is not 0xFE");

    a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !apb_req.pwdata[wdg_pkg::BIT_SRST]) |=> mcu_reset_req)
        else $error("clearing soft reset bit did not request reset");

    a_read_map: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_req.psel && !apb_req.penable && hit)
        |=> apb_rsp.pready && apb_rsp.prdata[7] == $past(s_reg.cnt[0])
            && apb_rsp.prdata[2] == $past(s_reg.cnt[5]))
        else $error("read image bit order wrong");

    a_timeout_rst: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !s_reg.stop && !wr && active && s_reg.cnt == wdg_pkg::CNT_LAST_SAFE)
        |=> mcu_reset_req)
        else $error("counter msb fall did not request reset");

    a_hw_forced: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.hw_s2 && apb_req.psel && !apb_req.penable && hit) |=> apb_rsp.prdata[0])
        else $error("hardware option did not read as active");

    a_act_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        !$fell(s_reg.act))
        else $error("activation bit cleared without reset");

    a_timer_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !s_reg.stop && !wr && !active && s_reg.cnt == 7'h00 && !s_reg.rst_req)
        |=> s_reg.cnt == wdg_pkg::CNT_RESET && !mcu_reset_req)
        else $error("inactive counter did not wrap quietly");

    a_wait_only: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_req && !s_reg.stop && active && !(s_reg.es_s2 && s_reg.nmi_s2)) |=> !stop_mode)
        else $error("stop entered while it should act as wait");

    a_stop_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.stop && !wr) |=> s_reg.cnt == $past(s_reg.cnt))
        else $error("counter moved while stopped");

    a_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.stop && wake_irq) |=> !stop_mode)
        else $error("interrupt did not leave stop");

    a_write_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr |=> s_reg.cnt == from_image($past(apb_req.pwdata[7:0])))
        else $error("write did not load the counter");

    a_tick_step: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !s_reg.stop && !wr) |=> s_reg.cnt == 7'($past(s_reg.cnt) - 7'h01))
        else $error("counter did not step down by one on a tick");

    a_write_grace: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && apb_req.pwdata[wdg_pkg::BIT_SRST] && !s_reg.rst_req) |=> !mcu_reset_req [*2])
        else $error("reset requested right after a reload");
endmodule

//--- bench/digital_watchdog_downcounter_bench.sv
// self-checking bench for the watchdog down counter and its apb register
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); fail_count++; end end
module digital_watchdog_downcounter_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------------
    logic pclk;
    logic presetn;
    wdg_pkg::wdg_apb_req_t apb_req;
    wdg_pkg::wdg_apb_rsp_t apb_rsp;
    logic hw_activation;
    logic ext_stop_ctrl;
    logic nmi_pin;
    logic stop_req;
    logic wake_irq;
    logic mcu_reset_req;
    logic stop_mode;
    int fail_count;
    int checks;
    logic [31:0] rd;
    logic err;
    int n;
    wdg_top dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .hw_activation(hw_activation),
        .ext_stop_ctrl(ext_stop_ctrl),
        .nmi_pin(nmi_pin),
        .stop_req(stop_req),
        .wake_irq(wake_irq),
        .mcu_reset_req(mcu_reset_req),
        .stop_mode(stop_mode)
    );
    always #12.5 pclk = ~pclk;
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // straps need two edges after release to settle, so wait a few more
    task automatic do_reset();
        @(posedge pclk) presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
            pwdata: {24'h000000, d}, pstrb: 4'hF};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        if (apb_rsp.pready !== 1'b1) begin
            fail_count++;
            stop_test();
        end else begin
            rd = apb_rsp.prdata;
            err = apb_rsp.pslverr;
            apb_req.psel <= 1'b0;
            apb_req.penable <= 1'b0;
        end
    endtask
    // counts edges until the reset request shows, bounded
    task automatic wait_rst();
        n = 0;
        while (mcu_reset_req !== 1'b1 && n < 7000) begin
            @(posedge pclk);
            n++;
        end
        if (mcu_reset_req !== 1'b1) begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic pulse_stop();
        @(posedge pclk) stop_req <= 1'b1;
        @(posedge pclk) stop_req <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_map();
        apb(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
        `CHK("reset image", 32'h000000FE, rd)
        `CHK("mapped err", 1'b0, err)
        apb(1'b0, 12'h0DC, 8'h00);
        `CHK("unmapped err", 1'b1, err)
        apb(1'b1, 12'h0DC, 8'h00);
        repeat (3) @(posedge pclk);
        `CHK("unmapped write no reset", 1'b0, mcu_reset_req)
    endtask
    task automatic t_soft_reset();
        apb(1'b1, wdg_pkg::CTRL_ADDR, 8'h03);
        apb(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
        `CHK("armed image", 32'h00000003, rd)
        // activation seen set, force a reset
        if (rd[wdg_pkg::BIT_ACT] === 1'b1) begin
            apb(1'b1, wdg_pkg::CTRL_ADDR, 8'hFD);
        end
        repeat (2) @(posedge pclk);
        `CHK("soft reset", 1'b1, mcu_reset_req)
        do_reset();
        `CHK("reset cleared", 1'b0, mcu_reset_req)
    endtask
    // armed, then a write with activation 0 must not disarm
    task automatic t_timeout();
        // period writes keep soft reset set
        apb(1'b1, wdg_pkg::CTRL_ADDR, 8'h03);
        apb(1'b1, wdg_pkg::CTRL_ADDR, 8'h02);
        wait_rst();
        `CHK("one tick timeout", 1'b1, n >= 3072 && n <= 3080)
        do_reset();
        apb(1'b1, wdg_pkg::CTRL_ADDR, 8'h83);
        apb(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
        `CHK("readback", 32'h00000083, rd)
        wait_rst();
        `CHK("two tick timeout", 1'b1, n >= 6138 && n <= 6152)
        do_reset();
    endtask
    task automatic t_stop_timer();
        apb(1'b1, wdg_pkg::CTRL_ADDR, 8'h02);
        pulse_stop();
        `CHK("stop entered", 1'b1, stop_mode)
        repeat (4000) @(posedge pclk);
        apb(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
        `CHK("frozen count", 32'h00000002, rd)
        @(posedge pclk) wake_irq <= 1'b1;
        @(posedge pclk) wake_irq <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("stop left", 1'b0, stop_mode)
        repeat (3100) @(posedge pclk);
        apb(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
        `CHK("timer count", 32'h000000FC, rd)
        `CHK("timer no reset", 1'b0, mcu_reset_req)
    endtask
    task automatic t_hw_option();
        hw_activation <= 1'b1;
        do_reset();
        apb(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
        `CHK("hw image", 32'h000000FF, rd)
        apb(1'b1, wdg_pkg::CTRL_ADDR, 8'hFE);
        apb(1'b0, wdg_pkg::CTRL_ADDR, 8'h00);
        `CHK("hw forced", 32'h000000FF, rd)
        pulse_stop();
        `CHK("stop as wait", 1'b0, stop_mode)
        ext_stop_ctrl <= 1'b1;
        repeat (4) @(posedge pclk);
        pulse_stop();
        `CHK("stop pin low", 1'b0, stop_mode)
        // pin released to its idle high
        nmi_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        pulse_stop();
        `CHK("stop pin high", 1'b1, stop_mode)
    endtask
    // ------------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn <= 1'b0;
        apb_req <= '0;
        hw_activation <= 1'b0;
        ext_stop_ctrl <= 1'b0;
        nmi_pin <= 1'b0;
        stop_req <= 1'b0;
        wake_irq <= 1'b0;
        fail_count = 0;
        checks = 0;
        do_reset();
        t_reset_map();
        t_soft_reset();
        t_timeout();
        t_stop_timer();
        t_hw_option();
        stop_test();
    end
    initial begin
        #2500000;
        fail_count++;
        stop_test();
    end
endmodule
